// ==== include/cod_pkg.sv ====
// package for the clock output divider: register map, fields, reset values, divider ladder
package cod_pkg;

  localparam int unsigned COD_CLK_HZ = 250_000_000;
  localparam int unsigned COD_ACC_W = 32;

  // register byte offsets
  localparam logic [7:0] COD_OFS_SETTINGS = 8'h00;
  localparam logic [7:0] COD_OFS_STATUS = 8'h04;
  localparam logic [7:0] COD_OFS_PERIODS = 8'h08;

  // settings register layout
  localparam int unsigned COD_SET_W = 8;
  localparam int unsigned COD_FREQ_LSB = 0;
  localparam int unsigned COD_FREQ_W = 3;
  localparam int unsigned COD_DUTY_LSB = 3;
  localparam int unsigned COD_DUTY_W = 2;
  localparam logic [7:0] COD_SET_RESET = 8'h12;
  localparam logic [2:0] COD_FREQ_RESET = 3'h2;
  localparam logic [1:0] COD_DUTY_RESET = 2'h2;

  // status register layout
  localparam int unsigned COD_ST_FREQ_LSB = 0;
  localparam int unsigned COD_ST_DUTY_LSB = 3;
  localparam int unsigned COD_ST_PEND_BIT = 5;
  localparam int unsigned COD_ST_RSVD_BIT = 6;
  localparam int unsigned COD_ST_LEVEL_BIT = 7;

  typedef enum logic [2:0] {
    COD_FREQ_RSVD = 3'h0,
    COD_FREQ_24M = 3'h1,
    COD_FREQ_12M = 3'h2,
    COD_FREQ_6M = 3'h3,
    COD_FREQ_3M = 3'h4,
    COD_FREQ_1M5 = 3'h5,
    COD_FREQ_750K = 3'h6,
    COD_FREQ_375K = 3'h7
  } cod_freq_e;

  typedef enum logic [1:0] {
    COD_DUTY_0 = 2'h0,
    COD_DUTY_25 = 2'h1,
    COD_DUTY_50 = 2'h2,
    COD_DUTY_75 = 2'h3
  } cod_duty_e;

  // output frequencies in Hz
  localparam longint unsigned COD_HZ_24M = 24_000_000;
  localparam longint unsigned COD_HZ_12M = 12_000_000;
  localparam longint unsigned COD_HZ_6M = 6_000_000;
  localparam longint unsigned COD_HZ_3M = 3_000_000;
  localparam longint unsigned COD_HZ_1M5 = 1_500_000;
  localparam longint unsigned COD_HZ_750K = 750_000;
  localparam longint unsigned COD_HZ_375K = 375_000;

  // phase step per clock = f * 2^ACC_W / f_clk, rounded to nearest
  function automatic logic [COD_ACC_W-1:0] cod_step(input longint unsigned hz);
    longint unsigned num;
    num = (hz << COD_ACC_W) + (64'(COD_CLK_HZ) >> 1);
    return COD_ACC_W'(num / 64'(COD_CLK_HZ));
  endfunction : cod_step

  localparam logic [COD_ACC_W-1:0] COD_STEP_24M = cod_step(COD_HZ_24M);
  localparam logic [COD_ACC_W-1:0] COD_STEP_12M = cod_step(COD_HZ_12M);
  localparam logic [COD_ACC_W-1:0] COD_STEP_6M = cod_step(COD_HZ_6M);
  localparam logic [COD_ACC_W-1:0] COD_STEP_3M = cod_step(COD_HZ_3M);
  localparam logic [COD_ACC_W-1:0] COD_STEP_1M5 = cod_step(COD_HZ_1M5);
  localparam logic [COD_ACC_W-1:0] COD_STEP_750K = cod_step(COD_HZ_750K);
  localparam logic [COD_ACC_W-1:0] COD_STEP_375K = cod_step(COD_HZ_375K);
  localparam logic [COD_ACC_W-1:0] COD_STEP_NONE = '0;

endpackage : cod_pkg

// ==== src/cod_phase_gen.sv ====
// phase accumulator that shapes the reference clock output and its duty cycle
`timescale 1ns/100ps
module cod_phase_gen
  import cod_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [cod_pkg::COD_ACC_W-1:0] step,
  input wire cod_pkg::cod_duty_e duty,
  output logic clkout,
  output logic wrap
);

  logic [COD_ACC_W-1:0] phase_q;
  logic [COD_ACC_W-1:0] phase_d;
  logic clkout_q;
  logic clkout_d;
  logic carry;

  // high-time test against the top two phase bits gives exact quarters
  function automatic logic cod_high(input cod_duty_e d, input logic [1:0] quad);
    logic r;
    r = 1'b0;
    case (d)
      COD_DUTY_75: r = (quad != 2'h3);
      COD_DUTY_50: r = (quad[1] == 1'b0);
      COD_DUTY_25: r = (quad == 2'h0);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : cod_high

  always_comb begin
    {carry, phase_d} = {1'b0, phase_q} + {1'b0, step};
    clkout_d = cod_high(duty, phase_d[COD_ACC_W-1 -: 2]);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_q <= '0;
      clkout_q <= 1'b0;
    end else if (ce) begin
      phase_q <= phase_d;
      clkout_q <= clkout_d;
    end
  end

  assign clkout = clkout_q;
  assign wrap = ce & carry;

endmodule : cod_phase_gen

// ==== src/cod_top.sv ====
// clock output divider with duty select, registers reached over APB
// Functional notes
// - duty code 11 gives output high three quarters, low one quarter of period
// - duty code 10 gives half high, half low; this is the reset default
// - duty code 01 gives output high one quarter, low three quarters
// - duty code 00 holds output low all period, no toggling
// - frequency code 111 gives 375 kHz, code 110 gives 750 kHz
// - frequency code 101 gives 1.5 MHz, code 100 gives 3 MHz
// - frequency code 010 gives 12 MHz and is the default; 011 gives 6 MHz
// - frequency code 001 gives 24 MHz; code 000 is reserved, never select
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
module cod_top
  import cod_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic clkout
);

  // programmed settings, as software last wrote them
  logic [COD_FREQ_W-1:0] freq_q;
  logic [COD_FREQ_W-1:0] freq_d;
  logic [COD_DUTY_W-1:0] duty_q;
  logic [COD_DUTY_W-1:0] duty_d;
  // settings currently driving the generator
  cod_freq_e act_freq_q;
  cod_freq_e act_freq_d;
  cod_duty_e act_duty_q;
  cod_duty_e act_duty_d;
  // output periods completed since reset
  logic [31:0] periods_q;
  logic [31:0] periods_d;
  // bus read path
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  logic setup;
  logic wr_set;
  logic pending;
  logic quiet;
  logic wrap;
  logic [COD_ACC_W-1:0] step;
  cod_duty_e gen_duty;

  function automatic logic [COD_ACC_W-1:0] cod_freq_step(input cod_freq_e f);
    logic [COD_ACC_W-1:0] s;
    s = COD_STEP_NONE;
    case (f)
      COD_FREQ_375K: s = COD_STEP_375K;
      COD_FREQ_750K: s = COD_STEP_750K;
      COD_FREQ_1M5: s = COD_STEP_1M5;
      COD_FREQ_3M: s = COD_STEP_3M;
      COD_FREQ_6M: s = COD_STEP_6M;
      COD_FREQ_12M: s = COD_STEP_12M;
      COD_FREQ_24M: s = COD_STEP_24M;
      default: s = COD_STEP_NONE; // reserved code parks the output low
    endcase
    return s;
  endfunction : cod_freq_step

  function automatic logic cod_addr_is(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : cod_addr_is

  // zero-wait slave; ce low stalls the access phase, but an access whose setup cycle falls while frozen gets stale prdata and pslverr
  assign pready = ce;
  assign setup = ce & psel & ~penable;
  // a write lands only at the edge that completes the access phase
  assign wr_set = ce & psel & penable & pwrite & pstrb[0] & cod_addr_is(paddr, COD_OFS_SETTINGS);

  // ---------------- settings register ----------------
  always_comb begin
    freq_d = freq_q;
    duty_d = duty_q;
    if (wr_set) begin
      // upper reserved bits are dropped on write and read back as zero
      freq_d = pwdata[COD_FREQ_LSB +: COD_FREQ_W];
      duty_d = pwdata[COD_DUTY_LSB +: COD_DUTY_W];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      freq_q <= COD_FREQ_RESET;
      duty_q <= COD_DUTY_RESET;
    end else if (ce) begin
      freq_q <= freq_d;
      duty_q <= duty_d;
    end
  end

  // ---------------- glitch-free hand-over ----------------
  // new settings take over only at a period boundary, so a change never
  // produces a runt pulse; a parked (silent) output takes them at once
  assign quiet = (act_duty_q == COD_DUTY_0) | (act_freq_q == COD_FREQ_RSVD);
  assign pending = (act_freq_q != cod_freq_e'(freq_q)) | (act_duty_q != cod_duty_e'(duty_q));

  always_comb begin
    act_freq_d = act_freq_q;
    act_duty_d = act_duty_q;
    if (wrap | quiet) begin
      act_freq_d = cod_freq_e'(freq_q);
      act_duty_d = cod_duty_e'(duty_q);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      act_freq_q <= COD_FREQ_12M;
      act_duty_q <= COD_DUTY_50;
    end else if (ce) begin
      act_freq_q <= act_freq_d;
      act_duty_q <= act_duty_d;
    end
  end

  assign step = cod_freq_step(act_freq_q);
  // shape with the settings about to take over, so the hand-over edge never
  // emits one stray high clock; a reserved rate freezes the phase, so park low
  assign gen_duty = (act_freq_d == COD_FREQ_RSVD) ? COD_DUTY_0 : act_duty_d;

  cod_phase_gen u_gen (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .step(step),
    .duty(gen_duty),
    .clkout(clkout),
    .wrap(wrap)
  );

  // ---------------- period counter ----------------
  // counts only periods that actually toggle the pin; wraps silently
  always_comb begin
    periods_d = periods_q;
    if (wrap && act_duty_q != COD_DUTY_0) begin
      periods_d = periods_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      periods_q <= 32'h0000_0000;
    end else if (ce) begin
      periods_q <= periods_d;
    end
  end

  // ---------------- read path ----------------
  // data is captured in the setup cycle so prdata comes from a flop yet the
  // access phase still completes without wait states
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (cod_addr_is(paddr, COD_OFS_SETTINGS)) begin
        if (!pwrite) begin
          prdata_d[COD_FREQ_LSB +: COD_FREQ_W] = freq_q;
          prdata_d[COD_DUTY_LSB +: COD_DUTY_W] = duty_q;
        end
      end else if (cod_addr_is(paddr, COD_OFS_STATUS)) begin
        if (!pwrite) begin
          prdata_d[COD_ST_FREQ_LSB +: COD_FREQ_W] = act_freq_q;
          prdata_d[COD_ST_DUTY_LSB +: COD_DUTY_W] = act_duty_q;
          prdata_d[COD_ST_PEND_BIT] = pending;
          prdata_d[COD_ST_RSVD_BIT] = (act_freq_q == COD_FREQ_RSVD);
          prdata_d[COD_ST_LEVEL_BIT] = clkout;
        end else begin
          pslverr_d = 1'b1;
        end
      end else if (cod_addr_is(paddr, COD_OFS_PERIODS)) begin
        if (!pwrite) begin
          prdata_d = periods_q;
        end else begin
          pslverr_d = 1'b1;
        end
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q & psel & penable;

endmodule : cod_top

// ==== testbench/cod_monitor.sv ====
// checker: output shape against a shadow of the settings register
`timescale 1ns/100ps
module cod_monitor
  import cod_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic clkout
);
  logic [4:0] set_q;
  logic [10:0] age_q;
  logic [9:0] cnt_q, hi_q;
  logic prev_q, ok_q, st, rise, fall;
  int p, q;
  // settled: no write or stall for longer than the slowest period
  assign st = age_q == 11'h5DC;
  assign rise = clkout & !prev_q;
  assign fall = !clkout & prev_q;
  assign q = int'(set_q[4:3]);
  assign p = 250_000_000 / (24_000_000 >> (set_q[2:0] - 3'h1));
  always_ff @(posedge clk) begin
    prev_q <= clkout;
    cnt_q <= rise ? 10'h1 : cnt_q + 10'h1;
    hi_q <= clkout ? hi_q + 10'h1 : 10'h0;
    if (!rstn) begin
      set_q <= COD_SET_RESET[4:0];
      age_q <= 11'h0;
      ok_q <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 8'h00 && pstrb[0]) begin
        set_q <= pwdata[4:0];
      end
      age_q <= (!ce || (psel && pwrite)) ? 11'h0 : st ? age_q : age_q + 11'h1;
      ok_q <= st && (ok_q || rise);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_fall; ok_q && fall; endsequence
  sequence s_rise; ok_q && rise; endsequence
  property p_duty75; s_fall ##0 q == 3 |-> 4*hi_q >= 3*p-4 && 4*hi_q <= 3*p+7; endproperty
  property p_duty50; s_fall ##0 q == 2 |-> 4*hi_q >= 2*p-4 && 4*hi_q <= 2*p+6; endproperty
  property p_duty25; s_fall ##0 q == 1 |-> 4*hi_q >= p-4 && 4*hi_q <= p+5; endproperty
  property p_duty0; st && q == 0 |-> !clkout; endproperty
  property p_rsvd; st && set_q[2:0] == 3'h0 |-> !clkout; endproperty
  property p_slow; s_rise ##0 set_q[2:0] > 3'h5 |-> cnt_q == p || cnt_q == p+1; endproperty
  property p_mid; s_rise ##0 set_q[2:1] == 2'h2 |-> cnt_q == p || cnt_q == p+1; endproperty
  property p_fast; s_rise ##0 set_q[2:1] == 2'h1 |-> cnt_q == p || cnt_q == p+1; endproperty
  property p_top; s_rise ##0 set_q[2:0] == 3'h1 |-> cnt_q == p || cnt_q == p+1; endproperty
  a_duty75: assert property (p_duty75) else $error("high time off at 75");
  a_duty50: assert property (p_duty50) else $error("high time off at 50");
  a_duty25: assert property (p_duty25) else $error("high time off at 25");
  a_duty0: assert property (p_duty0) else $error("output not held low");
  a_slow: assert property (p_slow) else $error("slow period off");
  a_mid: assert property (p_mid) else $error("mid period off");
  a_fast: assert property (p_fast) else $error("fast period off");
  a_top: assert property (p_top) else $error("top period off");
  a_rsvd: assert property (p_rsvd) else $error("reserved code toggles");
endmodule : cod_monitor

// ==== testbench/cod_clk_sink.sv ====
// partner model: external consumer timing the reference clock
`timescale 1ns/100ps
module cod_clk_sink (
  input wire logic clk,
  input wire logic clkout,
  output int per = 0,
  output int hi = 0,
  output int n = 0
);
  logic prev_q = 1'b0;
  int c = 0;
  int h = 0;
  always @(posedge clk) begin
    prev_q <= clkout;
    c <= (clkout && !prev_q) ? 1 : c + 1;
    h <= clkout ? h + 1 : 0;
    if (clkout && !prev_q) begin
      per <= c;
      n <= n + 1;
    end
    if (!clkout && prev_q) begin
      hi <= h;
    end
  end
endmodule : cod_clk_sink

// ==== testbench/cod_top_tb.sv ====
// testbench: register access and clock output shape
`timescale 1ns/100ps
module cod_top_tb;
  import cod_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, clkout, e;
  int per, hi, n, n0, p, q, fail_count = 0, checked = 0;
  // settings beside the period in clocks they should give
  int rows [7][2] = '{'{'h19, 10}, '{'h12, 20}, '{'h0B, 41}, '{'h1C, 83},
                      '{'h15, 166}, '{'h0E, 333}, '{'h17, 666}};
  always #2 clk = ~clk;
  cod_top u_cod_top (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clkout(clkout));
  cod_clk_sink u_cod_clk_sink (.clk(clk), .clkout(clkout), .per(per), .hi(hi), .n(n));
  task automatic chk(string s, logic [63:0] seen, logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // long wait first so the checker sees settled periods too
  task automatic wt(int c);
    repeat (c) @(posedge clk);
    n0 = n;
    for (int k = 0; k < 2800 && n < n0 + 3; k++) @(posedge clk);
  endtask : wt
  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    #240000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      p = rows[i][1];
      q = rows[i][0] >> 3;
      apb(1, 8'h00, rows[i][0], 4'hF);
      apb(0, 8'h00, 0, 4'hF);
      chk("readback", rd, rows[i][0]);
      wt(1600);
      chk("period", per == p || per == p + 1, 1);
      chk("high", 4*hi >= q*p - 4 && 4*hi <= q*(p + 1) + 4, 1);
    end
    // mid-run resets: output parks, defaults return, default 12 MHz period resumes
    for (int r = 0; r < 2; r++) begin
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      chk("rst_out", clkout, 0);
      rstn <= 1'b1;
      apb(0, COD_OFS_SETTINGS, 0, 4'hF);
      chk("reset", rd, 32'(COD_SET_RESET));
      apb(0, COD_OFS_STATUS, 0, 4'hF);
      chk("status", rd[5:0], 6'(COD_SET_RESET[4:0]));
      wt(1600);
      chk("def_period", per == 20 || per == 21, 1);
    end
    // the partner counts rises; the period register must agree within one
    apb(0, COD_OFS_PERIODS, 0, 4'hF);
    p = int'(rd);
    n0 = n;
    repeat (200) @(posedge clk);
    apb(0, COD_OFS_PERIODS, 0, 4'hF);
    q = int'(rd) - p - (n - n0);
    chk("periods", q >= -1 && q <= 1, 1);
    apb(1, 8'h00, 32'h02, 4'hF);
    wt(1600);
    chk("duty0", {clkout, n - n0}, 0);
    apb(1, 8'h00, 32'h10, 4'hF);
    wt(1600);
    chk("rsvd", {clkout, n - n0}, 0);
    apb(0, COD_OFS_STATUS, 0, 4'hF);
    chk("rsvd_flag", rd[6], 1);
    apb(1, 8'h00, 32'h1A, 4'h0);
    apb(0, 8'h00, 0, 4'hF);
    chk("no_strobe", rd, 32'h10);
    apb(0, 8'h0C, 0, 4'hF);
    chk("unmapped", {e, rd}, 33'h100000000);
    apb(1, COD_OFS_STATUS, 32'h1F, 4'hF);
    chk("ro_write", e, 1);
    ce <= 1'b0;
    @(posedge clk) chk("stall", pready, 0);
    ce <= 1'b1;
    finish_test();
  end
endmodule : cod_top_tb
bind cod_top cod_monitor u_cod_monitor (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .clkout(clkout));
